//--- hw/serial_ctrl_pkg.sv
// Constants, types and register map of the serial controller common registers.
// Assumes two controller instances share one Wishbone register window.
package serial_ctrl_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [15:0] A_PEND1 = 16'ha808;
  localparam logic [15:0] A_PEND2 = 16'ha80c;
  localparam logic [15:0] A_EN1 = 16'ha848;
  localparam logic [15:0] A_EN2 = 16'ha84c;
  localparam logic [15:0] A_TRIG1 = 16'ha854;
  localparam logic [15:0] A_TRIG2 = 16'ha858;
  localparam logic [15:0] A_PORT2 = 16'hc03c;
  localparam logic [15:0] A_MODE2 = 16'hc054;
  localparam logic [15:0] A_LIN2 = 16'hc060;
  localparam logic [15:0] A_EXP2 = 16'hc064;
  localparam logic [15:0] A_PORT1 = 16'hc83c;
  localparam logic [15:0] A_MODE1 = 16'hc854;
  localparam logic [15:0] A_LIN1 = 16'hc860;
  localparam logic [15:0] A_EXP1 = 16'hc864;

  // ----------------------------------------
  // Register kinds and field layout
  // ----------------------------------------
  localparam logic [2:0] K_PEND = 3'h0;
  localparam logic [2:0] K_EN = 3'h1;
  localparam logic [2:0] K_TRIG = 3'h2;
  localparam logic [2:0] K_PORT = 3'h3;
  localparam logic [2:0] K_MODE = 3'h4;
  localparam logic [2:0] K_LIN = 3'h5;
  localparam logic [2:0] K_EXP = 3'h6;

  localparam int FLAG_W = 15;
  localparam int B_PARITY = 14;
  localparam int B_FRAMING = 13;
  localparam int B_TXB = 12;
  localparam int B_RXA = 9;
  localparam int B_NOACK = 8;
  localparam int B_CMD = 7;
  localparam int B_SENT = 6;
  localparam int B_GOT = 5;
  localparam int B_UNDER = 4;
  localparam int B_OVER = 3;
  // Second controller has no parity or framing bits
  localparam logic [14:0] FLAG_MASK2 = 15'h1fff;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [14:0] PEND_RST = 15'h0000;
  localparam logic [14:0] EN_RST = 15'h0000;
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [3:0] RATE_RST = 4'h0;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_UART = 2'h1,
    MODE_SPI = 2'h2,
    MODE_I2C = 2'h3
  } mode_t;

  // Per-controller event pulses and status levels from the serial engines.
  // Status vectors: [2] line quiet, [1] tx space, [0] rx data available.
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic noack;
    logic cmd_done;
    logic byte_sent;
    logic byte_got;
    logic tx_under;
    logic rx_drop;
    logic [2:0] spi_stat;
    logic [2:0] uart_stat;
    logic dma_a_overflow;
    logic dma_b_overflow;
  } ctl_ev_t;

  // One DMA buffer as seen by the unload comparator
  typedef struct packed {
    logic loaded;
    logic [15:0] start_addr;
    logic [15:0] count;
    logic [15:0] end_addr;
  } dma_buf_t;

endpackage

//--- hw/serial_ctrl_common_regs.sv
// Common register set for two serial controllers: pending flags, enables,
// trigger selection, FIFO data port, mode and bit-rate divider.
// Assumes a classic Wishbone master, external FIFOs and DMA on the same clock.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps

module serial_ctrl_common_regs #(
  parameter int RATE_CNT_W = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ref_tick,
  input wire serial_ctrl_pkg::ctl_ev_t [1:0] ev,
  input wire serial_ctrl_pkg::dma_buf_t [3:0] dma_buf1,
  input wire serial_ctrl_pkg::dma_buf_t [3:0] dma_buf2,
  output logic [1:0] tx_push,
  output logic [1:0][7:0] tx_byte,
  output logic [1:0] rx_pop,
  input wire logic [1:0][7:0] rx_byte,
  input wire logic rx_head_parity,
  input wire logic rx_head_frame,
  input wire logic rx_empty,
  output logic uart_parity_q,
  output logic uart_frame_q,
  output logic [1:0] rx_ovr_stat,
  output logic [1:0][1:0] mode,
  output logic [1:0] rate_tick,
  output logic [1:0] irq
);

  // Largest divisor is 16 * 2^15, which needs 20 bits
  if (RATE_CNT_W < 20) begin : g_bad_width
    $error("RATE_CNT_W must be at least 20");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  typedef struct packed {
    logic hit;
    logic ctl;
    logic [2:0] kind;
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [15:0] a);
    reg_sel_t r;
    r = '{hit: 1'b1, ctl: 1'b0, kind: serial_ctrl_pkg::K_PEND};
    case (a)
      serial_ctrl_pkg::A_PEND1: r.kind = serial_ctrl_pkg::K_PEND;
      serial_ctrl_pkg::A_PEND2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_PEND};
      serial_ctrl_pkg::A_EN1: r.kind = serial_ctrl_pkg::K_EN;
      serial_ctrl_pkg::A_EN2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_EN};
      serial_ctrl_pkg::A_TRIG1: r.kind = serial_ctrl_pkg::K_TRIG;
      serial_ctrl_pkg::A_TRIG2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_TRIG};
      serial_ctrl_pkg::A_PORT1: r.kind = serial_ctrl_pkg::K_PORT;
      serial_ctrl_pkg::A_PORT2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_PORT};
      serial_ctrl_pkg::A_MODE1: r.kind = serial_ctrl_pkg::K_MODE;
      serial_ctrl_pkg::A_MODE2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_MODE};
      serial_ctrl_pkg::A_LIN1: r.kind = serial_ctrl_pkg::K_LIN;
      serial_ctrl_pkg::A_LIN2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_LIN};
      serial_ctrl_pkg::A_EXP1: r.kind = serial_ctrl_pkg::K_EXP;
      serial_ctrl_pkg::A_EXP2: r = '{1'b1, 1'b1, serial_ctrl_pkg::K_EXP};
      default: r.hit = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic unloaded(input serial_ctrl_pkg::dma_buf_t b);
    return b.loaded &&
      (({1'b0, b.start_addr} + {1'b0, b.count}) > {1'b0, b.end_addr});
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  bus_state_t bus_q, bus_d;
  logic [31:0] dat_q, dat_d;
  reg_sel_t rs;
  logic wr_go, rd_go;
  logic [31:0] wmask;

  logic [1:0][14:0] pend_q, pend_d, en_q, en_d;
  logic [1:0][2:0] trig_q, trig_d, lvl_prev_q, lvl_prev_d;
  logic [1:0][1:0] mode_q, mode_d;
  logic [1:0][3:0] lin_q, lin_d, exp_q, exp_d;
  logic [1:0] ovr_q, ovr_d, ovr_prev_q, ovr_prev_d;
  logic [1:0][3:0] unl_prev_q, unl_prev_d;
  logic [1:0][7:0] txb_q, txb_d;
  logic [1:0] push_q, push_d;
  logic pe_q, pe_d, fe_q, fe_d, reload_q, reload_d;
  logic [1:0][RATE_CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] tick_q, tick_d;

  assign rs = decode(adr_i);
  // Gated by ce: a frozen cycle must not show ack while the write cannot land
  assign ack_o = (bus_q == BUS_ACK) && ce;
  assign dat_o = dat_q;
  // Side effects land on the edge where the master samples ack
  assign wr_go = ack_o && we_i && rs.hit;
  assign rd_go = ack_o && !we_i && rs.hit;
  assign wmask = lane_mask(sel_i);

  always_comb begin
    bus_d = bus_q;
    dat_d = dat_q;
    case (bus_q)
      BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          bus_d = BUS_ACK;
          // Unmapped addresses still answer, reading zero
          dat_d = 32'h0000_0000;
          case (rs.kind)
            serial_ctrl_pkg::K_PEND: dat_d[14:0] = pend_q[rs.ctl];
            serial_ctrl_pkg::K_EN: dat_d[14:0] = en_q[rs.ctl];
            serial_ctrl_pkg::K_TRIG: dat_d[2:0] = trig_q[rs.ctl];
            serial_ctrl_pkg::K_PORT: dat_d[7:0] = rx_byte[rs.ctl];
            serial_ctrl_pkg::K_MODE: dat_d[1:0] = mode_q[rs.ctl];
            serial_ctrl_pkg::K_LIN: dat_d[3:0] = lin_q[rs.ctl];
            serial_ctrl_pkg::K_EXP: dat_d[3:0] = exp_q[rs.ctl];
            default: dat_d = 32'h0000_0000;
          endcase
          if (!rs.hit) begin
            dat_d = 32'h0000_0000;
          end
        end
      end
      BUS_ACK: bus_d = BUS_IDLE;
      default: bus_d = BUS_IDLE;
    endcase
  end

  // ----------------------------------------
  // Register file and event capture
  // ----------------------------------------
  logic [1:0][2:0] lvl;
  logic [1:0][3:0] unl_now;
  logic [1:0] ovr_src;
  logic [1:0][14:0] set;
  logic [1:0][14:0] keep;

  always_comb begin
    pend_d = pend_q;
    en_d = en_q;
    trig_d = trig_q;
    mode_d = mode_q;
    lin_d = lin_q;
    exp_d = exp_q;
    ovr_d = ovr_q;
    txb_d = txb_q;
    push_d = 2'b00;
    lvl = '0;
    unl_now = '0;
    ovr_src = '0;
    set = '0;
    keep = '1;
    for (int c = 0; c < 2; c++) begin
      // status from whichever of UART or SPI is active
      case (mode_q[c])
        serial_ctrl_pkg::MODE_UART: lvl[c] = ev[c].uart_stat;
        serial_ctrl_pkg::MODE_SPI: lvl[c] = ev[c].spi_stat;
        default: lvl[c] = 3'h0;
      endcase
      for (int b = 0; b < 4; b++) begin
        unl_now[c][b] = unloaded(c == 0 ? dma_buf1[b] : dma_buf2[b]);
      end
      ovr_src[c] = ovr_q[c] | ev[c].dma_a_overflow | ev[c].dma_b_overflow;

      set[c][serial_ctrl_pkg::B_PARITY] = ev[c].parity_err;
      set[c][serial_ctrl_pkg::B_FRAMING] = ev[c].frame_err;
      set[c][serial_ctrl_pkg::B_TXB:serial_ctrl_pkg::B_RXA] =
        unl_now[c] & ~unl_prev_q[c];
      set[c][serial_ctrl_pkg::B_NOACK] = ev[c].noack;
      set[c][serial_ctrl_pkg::B_CMD] = ev[c].cmd_done;
      set[c][serial_ctrl_pkg::B_SENT] = ev[c].byte_sent;
      set[c][serial_ctrl_pkg::B_GOT] = ev[c].byte_got;
      set[c][serial_ctrl_pkg::B_UNDER] = ev[c].tx_under;
      // overrun flag on rising overrun status
      set[c][serial_ctrl_pkg::B_OVER] = ovr_src[c] & ~ovr_prev_q[c];
      // edge or level capture of quiet, tx space, rx avail
      set[c][2:0] = lvl[c] & (trig_q[c] | ~lvl_prev_q[c]);

      if (wr_go && rs.ctl == c[0]) begin
        case (rs.kind)
          // writing zero clears a pending bit
          serial_ctrl_pkg::K_PEND: keep[c] = dat_i[14:0] | ~wmask[14:0];
          serial_ctrl_pkg::K_EN:
            en_d[c] = (en_q[c] & ~wmask[14:0]) | (dat_i[14:0] & wmask[14:0]);
          serial_ctrl_pkg::K_TRIG: if (sel_i[0]) trig_d[c] = dat_i[2:0];
          serial_ctrl_pkg::K_PORT: begin
            if (sel_i[0]) begin
              txb_d[c] = dat_i[7:0];
              push_d[c] = 1'b1;
            end
          end
          serial_ctrl_pkg::K_MODE: begin
            // UART refused on the second controller, falls to none
            if (sel_i[0]) begin
              mode_d[c] = dat_i[1:0];
              if (c == 1 && dat_i[1:0] == serial_ctrl_pkg::MODE_UART) begin
                mode_d[c] = serial_ctrl_pkg::MODE_NONE;
              end
            end
          end
          serial_ctrl_pkg::K_LIN: if (sel_i[0]) lin_d[c] = dat_i[3:0];
          serial_ctrl_pkg::K_EXP: if (sel_i[0]) exp_d[c] = dat_i[3:0];
          default: ;
        endcase
      end
      // Set wins over a same-cycle clear
      pend_d[c] = (pend_q[c] & keep[c]) | set[c];
      // data port read clears overrun status; a new drop still wins
      if (rd_go && rs.ctl == c[0] && rs.kind == serial_ctrl_pkg::K_PORT) begin
        ovr_d[c] = 1'b0;
      end
      if (ev[c].rx_drop) begin
        ovr_d[c] = 1'b1;
      end
    end
    // second controller has no parity or framing bits
    pend_d[1] = pend_d[1] & serial_ctrl_pkg::FLAG_MASK2;
    en_d[1] = en_d[1] & serial_ctrl_pkg::FLAG_MASK2;
  end

  assign lvl_prev_d = lvl;
  assign unl_prev_d = unl_now;
  assign ovr_prev_d = ovr_src;

  // pop is a combinational handshake on the acking edge
  always_comb begin
    rx_pop = 2'b00;
    if (rd_go && rs.kind == serial_ctrl_pkg::K_PORT) begin
      rx_pop[rs.ctl] = 1'b1;
    end
  end

  // ----------------------------------------
  // UART error status of the queue head
  // ----------------------------------------
  // The FIFO head moves one cycle after the pop, so reload a cycle later.
  always_comb begin
    pe_d = pe_q;
    fe_d = fe_q;
    reload_d = rx_pop[0];
    // load next byte status, clear when queue empty
    if (mode_q[0] == serial_ctrl_pkg::MODE_UART) begin
      if (rx_empty) begin
        pe_d = 1'b0;
        fe_d = 1'b0;
      end else if (reload_q) begin
        pe_d = rx_head_parity;
        fe_d = rx_head_frame;
      end
    end
  end

  // ----------------------------------------
  // Bit-rate divider
  // ----------------------------------------
  logic [1:0][RATE_CNT_W-1:0] limit;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 2'b00;
    for (int c = 0; c < 2; c++) begin
      // divisor (linear + 1) * 2^exponent in reference ticks
      limit[c] = RATE_CNT_W'({1'b0, lin_q[c]} + 5'h01) << exp_q[c];
      if (mode_q[c] == serial_ctrl_pkg::MODE_NONE) begin
        cnt_d[c] = '0;
      end else if (ref_tick) begin
        if (cnt_q[c] >= limit[c] - RATE_CNT_W'(1)) begin
          cnt_d[c] = '0;
          tick_d[c] = 1'b1;
        end else begin
          cnt_d[c] = cnt_q[c] + RATE_CNT_W'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_q <= BUS_IDLE;
      dat_q <= 32'h0000_0000;
      pend_q <= {2{serial_ctrl_pkg::PEND_RST}};
      en_q <= {2{serial_ctrl_pkg::EN_RST}};
      trig_q <= {2{serial_ctrl_pkg::TRIG_RST}};
      mode_q <= {2{serial_ctrl_pkg::MODE_NONE}};
      lin_q <= {2{serial_ctrl_pkg::RATE_RST}};
      exp_q <= {2{serial_ctrl_pkg::RATE_RST}};
      lvl_prev_q <= '0;
      unl_prev_q <= '0;
      ovr_q <= 2'b00;
      ovr_prev_q <= 2'b00;
      txb_q <= '0;
      push_q <= 2'b00;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      reload_q <= 1'b0;
      cnt_q <= '0;
      tick_q <= 2'b00;
    end else if (ce) begin
      bus_q <= bus_d;
      dat_q <= dat_d;
      pend_q <= pend_d;
      en_q <= en_d;
      trig_q <= trig_d;
      mode_q <= mode_d;
      lin_q <= lin_d;
      exp_q <= exp_d;
      lvl_prev_q <= lvl_prev_d;
      unl_prev_q <= unl_prev_d;
      ovr_q <= ovr_d;
      ovr_prev_q <= ovr_prev_d;
      txb_q <= txb_d;
      push_q <= push_d;
      pe_q <= pe_d;
      fe_q <= fe_d;
      reload_q <= reload_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tx_push = push_q & {2{ce}};
  assign tx_byte = txb_q;
  assign uart_parity_q = pe_q;
  assign uart_frame_q = fe_q;
  assign rx_ovr_stat = ovr_q;
  assign mode = mode_q;
  assign rate_tick = tick_q & {2{ce}};

  assign irq[0] = |(pend_q[0] & en_q[0]);
  assign irq[1] = |(pend_q[1] & en_q[1]);

endmodule

//--- sim/serial_ctrl_common_regs_props.sv
// Concurrent checks on the ports of the serial controller common registers.
// Assumes one clock domain and a synchronous active-high reset; bound below.
`timescale 1ns/1ps

module serial_ctrl_common_regs_props #(
  parameter int RATE_CNT_W = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire serial_ctrl_pkg::ctl_ev_t [1:0] ev,
  input wire logic [1:0] tx_push,
  input wire logic [1:0][7:0] tx_byte,
  input wire logic [1:0] rx_pop,
  input wire logic rx_empty,
  input wire logic uart_parity_q,
  input wire logic uart_frame_q,
  input wire logic [1:0] rx_ovr_stat,
  input wire logic [1:0][1:0] mode,
  input wire logic [1:0] irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  a_reset_all_zero: assert property ($fell(rst) |-> irq == 2'h0 && mode == '0 && !ack_o
    && rx_ovr_stat == 2'h0) else $error("outputs not zero after reset");
  a_port_write_push: assert property (ack_o && we_i && adr_i == serial_ctrl_pkg::A_PORT1
    && sel_i[0] && ce |=> tx_push[0] && tx_byte[0] == $past(dat_i[7:0]))
    else $error("data port write did not push its byte");
  a_port_read_pop: assert property (cyc_i && stb_i && ack_o && !we_i && ce
    && adr_i == serial_ctrl_pkg::A_PORT1 |-> rx_pop[0]) else $error("data port read without pop");
  a_pop_one_cycle: assert property (rx_pop[0] |=> !rx_pop[0])
    else $error("pop longer than one cycle");
  a_overrun_sets: assert property (ev[0].rx_drop && ce && !rx_pop[0] |=> rx_ovr_stat[0])
    else $error("overrun status not set");
  a_overrun_clears: assert property (rx_pop[0] && ce && !ev[0].rx_drop |=> !rx_ovr_stat[0])
    else $error("overrun status not cleared by read");
  a_second_no_uart: assert property (mode[1] != 2'h1)
    else $error("second controller in uart mode");
  a_mode_write_takes: assert property (ack_o && we_i && adr_i == serial_ctrl_pkg::A_MODE1
    && sel_i[0] && ce |=> mode[0] == $past(dat_i[1:0])) else $error("mode write lost");
  a_enable_off_quiet: assert property (ack_o && we_i && adr_i == serial_ctrl_pkg::A_EN1
    && sel_i == 4'hf && dat_i == 32'h0 |=> !irq[0]) else $error("irq with all enables off");
  a_empty_clears_stat: assert property (rx_empty && ce && mode[0] == 2'h1
    |=> !uart_parity_q && !uart_frame_q) else $error("uart status kept with empty fifo");
endmodule

bind serial_ctrl_common_regs serial_ctrl_common_regs_props #(.RATE_CNT_W(RATE_CNT_W)) u_props (
  .mclk, .rst, .ce, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .ev, .tx_push,
  .tx_byte, .rx_pop, .rx_empty, .uart_parity_q, .uart_frame_q, .rx_ovr_stat, .mode, .irq);

//--- sim/serial_ctrl_common_regs_tb_top.sv
// Self-checking bench for the serial controller common registers.
// Assumes the design package is compiled first; the bench drives every port.
`timescale 1ns/1ps

module serial_ctrl_common_regs_tb_top;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [15:0] adr_i = 16'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, uart_parity_q, uart_frame_q, ref_tick = 1'b0;
  logic rx_head_parity = 1'b0, rx_head_frame = 1'b0, rx_empty = 1'b1;
  serial_ctrl_pkg::ctl_ev_t [1:0] ev = '0;
  serial_ctrl_pkg::dma_buf_t [3:0] dma_buf1 = '0, dma_buf2 = '0;
  logic [1:0] tx_push, rx_pop, rx_ovr_stat, rate_tick, irq;
  logic [1:0][7:0] tx_byte, rx_byte = '0;
  logic [1:0][1:0] mode;
  int miscompares = 0, n_checks = 0, cc = 0;
  logic [15:0] pa [2] = '{serial_ctrl_pkg::A_PEND1, serial_ctrl_pkg::A_PEND2};
  logic [15:0] da [2] = '{serial_ctrl_pkg::A_PORT1, serial_ctrl_pkg::A_PORT2};

  serial_ctrl_common_regs u_dut (.mclk, .rst, .ce, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .ref_tick, .ev, .dma_buf1, .dma_buf2, .tx_push, .tx_byte, .rx_pop,
    .rx_byte, .rx_head_parity, .rx_head_frame, .rx_empty, .uart_parity_q, .uart_frame_q,
    .rx_ovr_stat, .mode, .rate_tick, .irq);

  // ----------------------------------------
  // Clock, reference tick, watchdog
  // ----------------------------------------
  always #2 mclk = ~mclk;

  // Reference tick every third cycle stands in for the slower rate source
  always @(posedge mclk) begin
    cc <= cc + 1;
    ref_tick <= (cc % 3 == 0);
  end

  // Whole run needs under a thousand cycles; 10000 leaves ample margin
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Classic cycle: hold the request until ack is sampled high, then release
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) chk(32'h0, 32'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [15:0] ra [15] = '{serial_ctrl_pkg::A_PEND1, serial_ctrl_pkg::A_PEND2,
      serial_ctrl_pkg::A_EN1, serial_ctrl_pkg::A_EN2, serial_ctrl_pkg::A_TRIG1,
      serial_ctrl_pkg::A_TRIG2, serial_ctrl_pkg::A_PORT2, serial_ctrl_pkg::A_MODE2,
      serial_ctrl_pkg::A_LIN2, serial_ctrl_pkg::A_EXP2, serial_ctrl_pkg::A_PORT1,
      serial_ctrl_pkg::A_MODE1, serial_ctrl_pkg::A_LIN1, serial_ctrl_pkg::A_EXP1, 16'h0000};
    foreach (ra[i]) rd(ra[i], 32'h0);
    $display("reset values done");
  endtask

  task automatic t_enables;
    wr(serial_ctrl_pkg::A_EN1, 32'hffffffff);
    rd(serial_ctrl_pkg::A_EN1, 32'h7fff);
    wr(serial_ctrl_pkg::A_EN2, 32'hffffffff);
    rd(serial_ctrl_pkg::A_EN2, 32'h1fff);
    wr(serial_ctrl_pkg::A_TRIG2, 32'hffffffff);
    rd(serial_ctrl_pkg::A_TRIG2, 32'h7);
    $display("enables done");
  endtask

  // Struct bit p of an event pulse maps to pending bit b
  task automatic t_events;
    int b;
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 16; p++) begin
        if (p inside {[2:7]}) continue;
        b = (p > 13) ? p - 1 : (p > 7) ? p - 5 : 3;
        if (c == 1 && b > 12) b = 31;
        ev[c] <= serial_ctrl_pkg::ctl_ev_t'(16'h1 << p);
        @(posedge mclk);
        ev[c] <= '0;
        repeat (3) @(posedge mclk);
        chk(32'(irq[c]), 32'(b != 31));
        rd(pa[c], (b == 31) ? 32'h0 : 32'h1 << b);
        wr(pa[c], 32'h0);
        rd(pa[c], 32'h0);
      end
    end
    $display("event flags done");
  endtask

  task automatic t_port;
    for (int c = 0; c < 2; c++) begin
      wr(da[c], 32'hffffff00 | (32'h5a + c));
      chk(32'(tx_byte[c]), 32'h5a + c);
      rx_byte[c] <= 8'hc3 ^ 8'(c);
      rd(da[c], 32'hc3 ^ c);
      chk(32'(rx_ovr_stat[c]), 32'h0);
    end
    $display("data port done");
  endtask

  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      wr(serial_ctrl_pkg::A_MODE1, 32'(m));
      rd(serial_ctrl_pkg::A_MODE1, 32'(m));
      wr(serial_ctrl_pkg::A_MODE2, 32'(m));
      rd(serial_ctrl_pkg::A_MODE2, (m == 1) ? 32'h0 : 32'(m));
    end
    $display("mode select done");
  endtask

  task automatic t_trigger;
    wr(serial_ctrl_pkg::A_MODE1, 32'h1);
    wr(serial_ctrl_pkg::A_TRIG1, 32'h0);
    ev[0].uart_stat <= 3'h1;
    ev[0].spi_stat <= 3'h2;
    repeat (3) @(posedge mclk);
    rd(serial_ctrl_pkg::A_PEND1, 32'h1);
    wr(serial_ctrl_pkg::A_PEND1, 32'h0);
    rd(serial_ctrl_pkg::A_PEND1, 32'h0);
    wr(serial_ctrl_pkg::A_TRIG1, 32'h1);
    rd(serial_ctrl_pkg::A_PEND1, 32'h1);
    wr(serial_ctrl_pkg::A_TRIG1, 32'h0);
    wr(serial_ctrl_pkg::A_PEND1, 32'h0);
    wr(serial_ctrl_pkg::A_MODE1, 32'h2);
    rd(serial_ctrl_pkg::A_PEND1, 32'h2);
    ev[0] <= '0;
    wr(serial_ctrl_pkg::A_PEND1, 32'h0);
    rd(serial_ctrl_pkg::A_PEND1, 32'h0);
    $display("trigger select done");
  endtask

  task automatic t_dma;
    for (int i = 0; i < 4; i++) begin
      dma_buf1[i] <= '{1'b1, 16'h0100, 16'h000f, 16'h010f};
      repeat (3) @(posedge mclk);
      rd(serial_ctrl_pkg::A_PEND1, 32'h0);
      dma_buf1[i].count <= 16'h0010;
      repeat (3) @(posedge mclk);
      rd(serial_ctrl_pkg::A_PEND1, 32'h1 << (9 + i));
      chk(32'(irq[0]), 32'h1);
      wr(serial_ctrl_pkg::A_EN1, 32'h0);
      chk(32'(irq[0]), 32'h0);
      wr(serial_ctrl_pkg::A_EN1, 32'h7fff);
      wr(serial_ctrl_pkg::A_PEND1, 32'h0);
      dma_buf1[i] <= '0;
    end
    $display("buffer unload done");
  endtask

  task automatic t_uart_stat;
    wr(serial_ctrl_pkg::A_MODE1, 32'h1);
    for (int k = 1; k < 3; k++) begin
      {rx_head_parity, rx_head_frame} <= 2'(k);
      rx_empty <= 1'b0;
      rd(serial_ctrl_pkg::A_PORT1, 32'hc3);
      repeat (3) @(posedge mclk);
      chk(32'({uart_parity_q, uart_frame_q}), 32'(k));
      rx_empty <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'({uart_parity_q, uart_frame_q}), 32'h0);
    end
    $display("uart status done");
  endtask

  // Count reference ticks over one output period, phase-independent
  task automatic t_rate;
    int n;
    int k;
    for (int s = 0; s < 2; s++) begin
      n = 0;
      k = 0;
      wr(serial_ctrl_pkg::A_LIN1, 32'(2 + s));
      wr(serial_ctrl_pkg::A_EXP1, 32'(1 + s));
      rd(serial_ctrl_pkg::A_EXP1, 32'(1 + s));
      while (rate_tick[0] !== 1'b1 && k < 400) begin
        @(posedge mclk);
        k++;
      end
      do begin
        n += 32'(ref_tick);
        @(posedge mclk);
        k++;
      end while (rate_tick[0] !== 1'b1 && k < 400);
      chk(32'(n), 32'((3 + s) << (1 + s)));
    end
    $display("bit rate done");
  endtask

  // Clock enable low freezes capture, so a pulse seen only then is lost
  task automatic t_freeze;
    ce <= 1'b0;
    ev[0].noack <= 1'b1;
    @(posedge mclk);
    ev[0] <= '0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    chk(32'(irq[0]), 32'h0);
    rd(serial_ctrl_pkg::A_PEND1, 32'h0);
    $display("clock enable done");
  endtask

  // A second reset in mid-run must bring back every register value
  task automatic t_rereset;
    rx_byte <= '0;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    $display("second reset done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_enables();
    t_events();
    t_port();
    t_mode();
    t_trigger();
    t_dma();
    t_uart_stat();
    t_rate();
    t_freeze();
    t_rereset();
    report_and_stop();
  end
endmodule
